// ### core/cogt_bank.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module cogt_bank #(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core2_sel_b,
  input wire logic core3_sel_d,
  input wire logic [11:0] core2_input_a_offset_trim,
  input wire logic [4:0] core2_input_a_gain_unused_guard,
  input wire logic fuse_load,
  input wire cogt_pkg::cogt_fuse_s fuse_default,
  output cogt_pkg::cogt_trim_s applied_trim
);
  import cogt_pkg::*;

  // Misaligned or unmapped addresses decode to no slot and answer with an error
  function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = IDX_W'(addr[ADDR_W-1:2]);
    if (addr[1:0] != 2'b00)
      slot_of = SLOT_NONE;
    else
      case (idx)
        IDX_C2B_OFFSET: slot_of = SLOT_C2B_OFFSET;
        IDX_C3C_OFFSET: slot_of = SLOT_C3C_OFFSET;
        IDX_C3D_OFFSET: slot_of = SLOT_C3D_OFFSET;
        IDX_C4_OFFSET: slot_of = SLOT_C4_OFFSET;
        IDX_C5_OFFSET: slot_of = SLOT_C5_OFFSET;
        IDX_C0_GAIN: slot_of = SLOT_C0_GAIN;
        IDX_C1_GAIN: slot_of = SLOT_C1_GAIN;
        IDX_C2A_GAIN: slot_of = SLOT_C2A_GAIN;
        IDX_C2B_GAIN: slot_of = SLOT_C2B_GAIN;
        IDX_STATUS: slot_of = SLOT_STATUS;
        default: slot_of = SLOT_NONE;
      endcase
  endfunction

  // Offset slots come first, so the low three bits index the offset array
  function automatic logic [2:0] ofs_pos(input logic [3:0] slot);
    ofs_pos = slot[2:0];
  endfunction

  // Gain slots follow the offset slots in the slot numbering
  function automatic logic [1:0] gain_pos(input logic [3:0] slot);
    logic [3:0] rel;
    rel = slot - SLOT_C0_GAIN;
    gain_pos = rel[1:0];
  endfunction

  // Byte-lane merge; reserved bits are stored as written, software keeps them zero
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0])
      merge16[7:0] = d[7:0];
    if (strb[1])
      merge16[15:8] = d[15:8];
  endfunction

  // Gain registers are one byte wide, so only the lowest lane reaches them
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge8 = old;
    if (strb[0])
      merge8 = d[7:0];
  endfunction

  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic aw_full_reg, aw_full_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic w_full_reg, w_full_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0][15:0] ofs_reg, ofs_next;
  logic [3:0][7:0] gain_reg, gain_next;
  cogt_trim_s applied_reg, applied_next;
  logic do_write;
  logic [3:0] wslot, rslot;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign applied_trim = applied_reg;

  // Write channel: address and data are held independently until both are in
  always_comb
  begin
    aw_addr_next = aw_addr_reg;
    aw_full_next = aw_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    w_full_next = w_full_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    wslot = slot_of(aw_addr_reg);
    do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    if (s_axi_awvalid && !aw_full_reg)
    begin
      aw_addr_next = s_axi_awaddr;
      aw_full_next = 1'b1;
    end
    if (s_axi_wvalid && !w_full_reg)
    begin
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
      w_full_next = 1'b1;
    end
    if (do_write)
    begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wslot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  // Trim storage: fuse load first, a software write in the same cycle wins
  always_comb
  begin
    ofs_next = ofs_reg;
    gain_next = gain_reg;
    if (fuse_load)
    begin
      ofs_next = fuse_default.ofs;
      gain_next = fuse_default.gain;
    end
    if (do_write)
      case (wslot)
        SLOT_C2B_OFFSET, SLOT_C3C_OFFSET, SLOT_C3D_OFFSET, SLOT_C4_OFFSET, SLOT_C5_OFFSET:
          ofs_next[ofs_pos(wslot)] = merge16(ofs_reg[ofs_pos(wslot)], w_data_reg, w_strb_reg);
        SLOT_C0_GAIN, SLOT_C1_GAIN, SLOT_C2A_GAIN, SLOT_C2B_GAIN:
          gain_next[gain_pos(wslot)] = merge8(gain_reg[gain_pos(wslot)], w_data_reg, w_strb_reg);
        default:
          ;
      endcase
  end

  // Read channel: one read in flight, answered the cycle after it is taken
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    rslot = slot_of(s_axi_araddr);
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case (rslot)
        SLOT_C2B_OFFSET, SLOT_C3C_OFFSET, SLOT_C3D_OFFSET, SLOT_C4_OFFSET, SLOT_C5_OFFSET:
          rdata_next[15:0] = ofs_reg[ofs_pos(rslot)];
        SLOT_C0_GAIN, SLOT_C1_GAIN, SLOT_C2A_GAIN, SLOT_C2B_GAIN:
          rdata_next[7:0] = gain_reg[gain_pos(rslot)];
        SLOT_STATUS:
        begin
          rdata_next[STAT_SEL2_BIT] = core2_sel_b;
          rdata_next[STAT_SEL3_BIT] = core3_sel_d;
        end
        default:
          rresp_next = RESP_SLVERR;
      endcase
    end
  end

  // Applied trims follow the sampled input; values pass on as unsigned codes
  always_comb
  begin
    applied_next = applied_reg;
    if (core2_sel_b)
      applied_next.core2_offset = ofs_reg[ofs_pos(SLOT_C2B_OFFSET)][OFS_MSB:0];
    else
      applied_next.core2_offset = core2_input_a_offset_trim;
    if (core3_sel_d)
      applied_next.core3_offset = ofs_reg[ofs_pos(SLOT_C3D_OFFSET)][OFS_MSB:0];
    else
      applied_next.core3_offset = ofs_reg[ofs_pos(SLOT_C3C_OFFSET)][OFS_MSB:0];
    applied_next.core4_offset = ofs_reg[ofs_pos(SLOT_C4_OFFSET)][OFS_MSB:0];
    applied_next.core5_offset = ofs_reg[ofs_pos(SLOT_C5_OFFSET)][OFS_MSB:0];
    applied_next.core0_gain = gain_reg[gain_pos(SLOT_C0_GAIN)][GAIN_MSB:0];
    applied_next.core1_gain = gain_reg[gain_pos(SLOT_C1_GAIN)][GAIN_MSB:0];
    if (core2_sel_b)
      applied_next.core2_gain = gain_reg[gain_pos(SLOT_C2B_GAIN)][GAIN_MSB:0];
    else
      applied_next.core2_gain = gain_reg[gain_pos(SLOT_C2A_GAIN)][GAIN_MSB:0];
  end

  // Holding stages of the write path
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_addr_reg <= '0;
      aw_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      w_full_reg <= 1'b0;
    end
    else
    begin
      aw_addr_reg <= aw_addr_next;
      aw_full_reg <= aw_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      w_full_reg <= w_full_next;
    end
  end

  // Write response
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Read answer
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Trim storage; reset leaves zeros until a fuse load brings the defaults
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ofs_reg <= {5{OFS_RESET}};
      gain_reg <= {4{GAIN_RESET}};
    end
    else
    begin
      ofs_reg <= ofs_next;
      gain_reg <= gain_next;
    end
  end

  // Applied trims
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      applied_reg <= '0;
    end
    else
    begin
      applied_reg <= applied_next;
    end
  end

endmodule // cogt_bank
`default_nettype wire

// ### inc/cogt_pkg.sv
`default_nettype none
package cogt_pkg;

  // Register indices; byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_C2B_OFFSET = 10'h336;
  localparam logic [IDX_W-1:0] IDX_C3C_OFFSET = 10'h338;
  localparam logic [IDX_W-1:0] IDX_C3D_OFFSET = 10'h33A;
  localparam logic [IDX_W-1:0] IDX_C4_OFFSET = 10'h33C;
  localparam logic [IDX_W-1:0] IDX_C5_OFFSET = 10'h33E;
  localparam logic [IDX_W-1:0] IDX_C0_GAIN = 10'h360;
  localparam logic [IDX_W-1:0] IDX_C1_GAIN = 10'h361;
  localparam logic [IDX_W-1:0] IDX_C2A_GAIN = 10'h362;
  localparam logic [IDX_W-1:0] IDX_C2B_GAIN = 10'h363;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h370;

  // Slot numbers inside the bank
  localparam logic [3:0] SLOT_C2B_OFFSET = 4'h0;
  localparam logic [3:0] SLOT_C3C_OFFSET = 4'h1;
  localparam logic [3:0] SLOT_C3D_OFFSET = 4'h2;
  localparam logic [3:0] SLOT_C4_OFFSET = 4'h3;
  localparam logic [3:0] SLOT_C5_OFFSET = 4'h4;
  localparam logic [3:0] SLOT_C0_GAIN = 4'h5;
  localparam logic [3:0] SLOT_C1_GAIN = 4'h6;
  localparam logic [3:0] SLOT_C2A_GAIN = 4'h7;
  localparam logic [3:0] SLOT_C2B_GAIN = 4'h8;
  localparam logic [3:0] SLOT_STATUS = 4'h9;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // Field layout
  localparam int OFS_MSB = 11;
  localparam int GAIN_MSB = 4;
  localparam int STAT_SEL2_BIT = 0;
  localparam int STAT_SEL3_BIT = 1;

  // Reset values
  localparam logic [15:0] OFS_RESET = 16'h0000;
  localparam logic [7:0] GAIN_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [4:0][15:0] ofs;
    logic [3:0][7:0] gain;
  } cogt_fuse_s;

  typedef struct packed {
    logic [11:0] core2_offset;
    logic [11:0] core3_offset;
    logic [11:0] core4_offset;
    logic [11:0] core5_offset;
    logic [4:0] core0_gain;
    logic [4:0] core1_gain;
    logic [4:0] core2_gain;
  } cogt_trim_s;

endpackage
`default_nettype wire

// ### testbench/cogt_bank_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cogt_bank_monitor
  import cogt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic core2_sel_b,
  input wire logic [11:0] core2_input_a_offset_trim,
  input wire logic fuse_load,
  input wire cogt_fuse_s fuse_default,
  input wire cogt_trim_s applied_trim
);
  logic ar_go;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_read_resp: assert property (ar_go |=> s_axi_rvalid) else $error("read data late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read");
  chk_bad_addr: assert property (ar_go && s_axi_araddr[1:0] != 2'b00 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("misaligned read");
  chk_ofs_upper: assert property (
    ar_go && s_axi_araddr == ADDR_W'({IDX_C4_OFFSET, 2'b00}) |=> s_axi_rdata[31:16] == 16'h0000)
    else $error("offset upper bits set");
  chk_gain_upper: assert property (
    ar_go && s_axi_araddr == ADDR_W'({IDX_C0_GAIN, 2'b00}) |=> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("gain upper bits set");
  chk_core2_a: assert property (
    !core2_sel_b |=> applied_trim.core2_offset == $past(core2_input_a_offset_trim))
    else $error("core two first input offset");
  chk_fuse_ofs: assert property (
    fuse_load && s_axi_awready && s_axi_wready |-> ##3
    applied_trim.core5_offset == $past(fuse_default.ofs[4][11:0], 3)) else $error("fuse load");
  cover property (fuse_load);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // cogt_bank_monitor
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import cogt_pkg::*;
  localparam logic [9:0] ix [9] = '{IDX_C2B_OFFSET, IDX_C3C_OFFSET, IDX_C3D_OFFSET,
    IDX_C4_OFFSET, IDX_C5_OFFSET, IDX_C0_GAIN, IDX_C1_GAIN, IDX_C2A_GAIN, IDX_C2B_GAIN};
  logic sys_clk = 1'b0, rstn = 1'b0, core2_sel_b = 1'b0, core3_sel_d = 1'b0, fuse_load = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, core2_input_a_offset_trim = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, lf = 32'h7f01, t, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] m [9];
  cogt_fuse_s fuse_default = '0;
  cogt_trim_s applied_trim;
  int miscompares = 0, num_checks = 0, i, k;
  always #4 sys_clk = ~sys_clk;
  cogt_bank #(.ADDR_W(12)) dut_u (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .core2_sel_b, .core3_sel_d, .core2_input_a_offset_trim,
    .core2_input_a_gain_unused_guard(5'h00), .fuse_load, .fuse_default, .applied_trim);
  function automatic logic [31:0] nx();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic cogt_trim_s exp_t();
    cogt_trim_s e;
    e.core2_offset = core2_sel_b ? m[0][11:0] : core2_input_a_offset_trim;
    e.core3_offset = core3_sel_d ? m[2][11:0] : m[1][11:0];
    e.core4_offset = m[3][11:0];
    e.core5_offset = m[4][11:0];
    e.core0_gain = m[5][4:0];
    e.core1_gain = m[6][4:0];
    e.core2_gain = core2_sel_b ? m[8][4:0] : m[7][4:0];
    return e;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One task for both directions keeps the handshake code in one place
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    logic ta, tw, tr, dn;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    dn = 1'b0;
    for (int n = 0; !dn; n++)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      d = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      if (n > 40)
      begin
        miscompares++;
        tally_and_finish();
      end
      @(posedge sys_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tr)
        s_axi_arvalid <= 1'b0;
      if (dn)
        s_axi_bready <= 1'b0;
      if (dn)
        s_axi_rready <= 1'b0;
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    for (i = 0; i < 9; i++)
    begin
      m[i] = 16'h0000;
      bus(1'b0, {ix[i], 2'b00}, 32'h0000_0000);
      chk(d, 64'h0);
    end
    for (k = 0; k < 12; k++)
    begin
      for (i = 0; i < 9; i++)
      begin
        t = nx();
        m[i] = i < 5 ? {4'h0, t[11:0]} : {11'h000, t[4:0]};
        bus(1'b1, {ix[i], 2'b00}, {16'h0000, m[i]});
        chk(r, RESP_OKAY);
      end
      t = nx();
      core2_sel_b <= k[0];
      core3_sel_d <= k[1];
      core2_input_a_offset_trim <= t[11:0];
      settle();
      chk(applied_trim, exp_t());
      bus(1'b0, {ix[k % 9], 2'b00}, 32'h0000_0000);
      chk(d, m[k % 9]);
      bus(1'b0, {IDX_STATUS, 2'b00}, 32'h0000_0000);
      chk(d, {core3_sel_d, core2_sel_b});
    end
    bus(1'b1, 12'h004, 32'h0000_0001);
    chk(r, RESP_SLVERR);
    bus(1'b0, 12'hd82, 32'h0000_0000);
    chk({d, 30'h0, r}, {32'h0, 30'h0, RESP_SLVERR});
    s_axi_wstrb <= 4'h1;
    bus(1'b1, {IDX_C4_OFFSET, 2'b00}, 32'h0000_0f5a);
    s_axi_wstrb <= 4'hf;
    m[3][7:0] = 8'h5a;
    bus(1'b0, {IDX_C4_OFFSET, 2'b00}, 32'h0000_0000);
    chk(d, m[3]);
    for (i = 0; i < 9; i++)
    begin
      t = nx();
      m[i] = i < 5 ? {4'h0, t[11:0]} : {11'h000, t[4:0]};
      if (i < 5)
        fuse_default.ofs[i] <= m[i];
      else
        fuse_default.gain[i - 5] <= m[i][7:0];
    end
    @(posedge sys_clk);
    fuse_load <= 1'b1;
    @(posedge sys_clk);
    fuse_load <= 1'b0;
    settle();
    chk(applied_trim, exp_t());
    bus(1'b0, {IDX_C3D_OFFSET, 2'b00}, 32'h0000_0000);
    chk(d, m[2]);
    tally_and_finish();
  end
endmodule // tb
bind cogt_bank cogt_bank_monitor #(.ADDR_W(ADDR_W)) mon_u (.sys_clk, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .core2_sel_b, .core2_input_a_offset_trim, .fuse_load, .fuse_default,
  .applied_trim);
`default_nettype wire
